//--- dv/qdr_media_model.sv
// Far-side model: media buffer and DMA channel pacing sectors and blocks.
`timescale 1ns/10ps
`default_nettype none
module qdr_media_model (
    input  wire logic        i_clk_sys,      // System clock
    input  wire logic        i_rst,          // Synchronous reset, high
    input  wire logic        i_dmarq,        // Sector transfer request
    input  wire logic        i_drq,          // Log block request
    input  wire logic        i_ready_req,    // Bench asks for buffered data
    input  wire logic [7:0]  i_gap,          // Cycles per unit, at least 2
    input  wire logic [16:0] i_err_at,       // Failing unit index
    output logic             o_data_ready,   // Data buffered
    output logic             o_sector_done,  // Sector moved
    output logic             o_media_err,    // Unrecoverable error
    output logic             o_log_blk_done, // Log block moved
    output logic      [16:0] o_n_sect,       // Sectors moved so far
    output logic      [16:0] o_n_blk         // Log blocks moved so far
);
    logic [7:0]  wait_q;
    logic [16:0] idx_q;

    always_ff @(posedge i_clk_sys) begin
        o_sector_done  <= 1'b0;
        o_media_err    <= 1'b0;
        o_log_blk_done <= 1'b0;
        o_data_ready   <= i_ready_req;
        if (i_rst) begin
            wait_q   <= 8'h00;
            idx_q    <= 17'h00000;
            o_n_sect <= 17'h00000;
            o_n_blk  <= 17'h00000;
        end else if (!(i_dmarq || i_drq)) begin
            wait_q <= 8'h00;
            idx_q  <= 17'h00000;
        end else if (wait_q + 8'h01 < i_gap) begin
            wait_q <= wait_q + 8'h01;
        end else begin
            wait_q <= 8'h00;
            idx_q  <= idx_q + 17'h00001;
            if (i_drq) begin
                o_log_blk_done <= 1'b1;
                o_n_blk        <= o_n_blk + 17'h00001;
            end else if (idx_q == i_err_at) begin
                o_media_err <= 1'b1;
            end else begin
                o_sector_done <= 1'b1;
                o_n_sect      <= o_n_sect + 17'h00001;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the queued read handler.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        i_clk_sys, i_rst, i_read, i_write, o_waitrequest, o_irq;
    logic        i_data_ready, i_sector_done, i_media_err, i_smart_en;
    logic        i_log_blk_done, o_dmarq, o_drq, ready_req;
    logic [5:0]  i_address;
    logic [31:0] i_writedata, o_readdata, rd;
    logic [3:0]  i_byteenable;
    logic [47:0] o_rd_lba;
    logic [7:0]  o_log_addr, gap;
    logic [15:0] o_log_sector;
    logic [16:0] err_at, n_sect, n_blk, base;
    int          err_count, comparisons;
    int          cyc = 0;
    logic [47:0] logtab [8] = '{48'h2f_80_02_0e_01_02, 48'h2f_00_01_00_00_01,
        48'h2f_03_01_00_00_00, 48'h2f_06_01_00_01_00, 48'h2f_80_00_00_01_00,
        48'h2f_07_01_00_01_01, 48'h2f_80_01_10_01_00,
        48'hff_80_01_10_01_00};

    qdr_top qdr_top_i (.i_clk_sys, .i_rst, .i_address, .i_read, .i_write,
        .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
        .i_data_ready, .i_sector_done, .i_media_err, .i_smart_en,
        .i_log_blk_done, .o_dmarq, .o_drq, .o_rd_lba, .o_log_addr,
        .o_log_sector, .o_irq);

    qdr_media_model qdr_media_model_i (.i_clk_sys, .i_rst, .i_dmarq(o_dmarq),
        .i_drq(o_drq), .i_ready_req(ready_req), .i_gap(gap),
        .i_err_at(err_at), .o_data_ready(i_data_ready),
        .o_sector_done(i_sector_done), .o_media_err(i_media_err),
        .o_log_blk_done(i_log_blk_done), .o_n_sect(n_sect), .o_n_blk(n_blk));

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    task automatic close_out();
        $display("errors %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon access; the request stands until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        i_address   <= a;
        i_write     <= wr;
        i_read      <= ~wr;
        i_writedata <= {24'h000000, d};
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) err_count++;
        rd = o_readdata;
        i_read  <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic wait_for(input int w);
        int  n;
        logic ok;
        n  = 0;
        ok = 1'b0;
        while (!ok && n < 2000) begin
            @(posedge i_clk_sys);
            n++;
            case (w)
                0: ok = (o_dmarq === 1'b1);
                1: ok = (o_dmarq === 1'b0 && o_irq === 1'b1);
                2: ok = (o_drq === 1'b0 && o_irq === 1'b1);
                default: ok = (o_irq === 1'b1);
            endcase
        end
        if (!ok) err_count++;
    endtask

    // Previous bytes go first so that the second write shadows them.
    task automatic setup(input logic [7:0] op, fhi, flo, sc,
                         input logic [47:0] lba);
        bus(1'b1, qdr_pkg::OFS_FEAT, fhi);
        bus(1'b1, qdr_pkg::OFS_FEAT, flo);
        bus(1'b1, qdr_pkg::OFS_SCNT, 8'h00);
        bus(1'b1, qdr_pkg::OFS_SCNT, sc);
        bus(1'b1, qdr_pkg::OFS_SNUM, lba[31:24]);
        bus(1'b1, qdr_pkg::OFS_SNUM, lba[7:0]);
        bus(1'b1, qdr_pkg::OFS_CYLO, lba[39:32]);
        bus(1'b1, qdr_pkg::OFS_CYLO, lba[15:8]);
        bus(1'b1, qdr_pkg::OFS_CYHI, lba[47:40]);
        bus(1'b1, qdr_pkg::OFS_CYHI, lba[23:16]);
        bus(1'b1, qdr_pkg::OFS_DEVHEAD, {4'he, lba[27:24]});
        bus(1'b1, qdr_pkg::OFS_CMD, op);
    endtask

    task automatic queued(input logic [7:0] op, fhi, flo,
        input logic [4:0] tag, input logic [47:0] lba, input logic [16:0] n);
        base = n_sect;
        setup(op, fhi, flo, {tag, 3'b000}, lba);
        wait_for(0);
        chk(o_rd_lba, lba);
        wait_for(1);
        chk(n_sect - base, n);
        bus(1'b0, qdr_pkg::OFS_IRQ_ST, 8'h00);
        chk(rd[2:0], 3'b010);
        bus(1'b0, qdr_pkg::OFS_SCNT, 8'h00);
        chk(rd[7:0], {tag, qdr_pkg::SC_COMPLETE});
        bus(1'b0, qdr_pkg::OFS_STATUS, 8'h00);
        chk(rd[qdr_pkg::ST_ERR], err_at != 17'h1ffff);
    endtask

    task automatic release_service();
        ready_req <= 1'b0;
        base = n_sect;
        setup(8'hc7, 8'h00, 8'h03, {5'h15, 3'b000}, 48'h000001234567);
        wait_for(3);
        chk(o_dmarq, 1'b0);
        bus(1'b0, qdr_pkg::OFS_SCNT, 8'h00);
        chk(rd[7:0], {5'h15, qdr_pkg::SC_RELEASE});
        bus(1'b0, qdr_pkg::OFS_STATUS, 8'h00);
        chk({rd[qdr_pkg::ST_BSY], rd[qdr_pkg::ST_SRV]}, 2'b00);
        bus(1'b1, qdr_pkg::OFS_IRQ_MSK, 8'h00);
        repeat (2) @(posedge i_clk_sys);
        chk(o_irq, 1'b0);
        bus(1'b1, qdr_pkg::OFS_IRQ_MSK, 8'h07);
        repeat (2) @(posedge i_clk_sys);
        chk(o_irq, 1'b1);
        bus(1'b0, qdr_pkg::OFS_IRQ_ST, 8'h00);
        chk(rd[2:0], 3'b001);
        repeat (2) @(posedge i_clk_sys);
        chk(o_irq, 1'b0);
        ready_req <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        bus(1'b0, qdr_pkg::OFS_STATUS, 8'h00);
        chk(rd[qdr_pkg::ST_SRV], 1'b1);
        bus(1'b1, qdr_pkg::OFS_CMD, qdr_pkg::OP_SERVICE);
        wait_for(0);
        wait_for(1);
        chk(n_sect - base, 17'd3);
        bus(1'b0, qdr_pkg::OFS_SCNT, 8'h00);
        chk(rd[7:0], {5'h15, qdr_pkg::SC_COMPLETE});
        bus(1'b0, qdr_pkg::OFS_STATUS, 8'h00);
        chk(rd[qdr_pkg::ST_SRV], 1'b0);
        bus(1'b0, qdr_pkg::OFS_IRQ_ST, 8'h00);
    endtask

    task automatic error48();
        err_at <= 17'd1;
        queued(8'h26, 8'h00, 8'h03, 5'h09, 48'h665544332211, 17'd1);
        bus(1'b0, qdr_pkg::OFS_ERROR, 8'h00);
        chk(rd[qdr_pkg::ER_UNC], 1'b1);
        bus(1'b0, qdr_pkg::OFS_SNUM, 8'h00);
        chk(rd[7:0], 8'h12);
        bus(1'b1, qdr_pkg::OFS_DEVCTL, 8'h80);
        bus(1'b0, qdr_pkg::OFS_SNUM, 8'h00);
        chk(rd[7:0], 8'h44);
        bus(1'b0, qdr_pkg::OFS_CYHI, 8'h00);
        chk(rd[7:0], 8'h66);
        bus(1'b1, qdr_pkg::OFS_DEVCTL, 8'h00);
        err_at <= 17'h1ffff;
    endtask

    task automatic log_case(input logic [47:0] e);
        logic ab;
        ab = (e[7:0] == 8'h00);
        i_smart_en <= e[8];
        base = n_blk;
        setup(e[47:40], 8'h00, 8'h00, e[31:24], {32'h0, e[23:16], e[39:32]});
        wait_for(2);
        chk(n_blk - base, {9'h000, e[7:0]});
        chk({o_log_addr, o_log_sector},
            {e[39:32], 8'h00, e[23:16] + e[7:0]});
        bus(1'b0, qdr_pkg::OFS_IRQ_ST, 8'h00);
        chk(rd[2:0], ab ? 3'b010 : 3'b100);
        bus(1'b0, qdr_pkg::OFS_STATUS, 8'h00);
        chk(rd[qdr_pkg::ST_ERR], ab);
        bus(1'b0, qdr_pkg::OFS_ERROR, 8'h00);
        chk(rd[qdr_pkg::ER_ABT], ab);
    endtask

    initial begin
        i_rst = 1'b1;
        i_read = 1'b0;
        i_write = 1'b0;
        i_address = 6'h00;
        i_writedata = 32'h00000000;
        i_byteenable = 4'hf;
        i_smart_en = 1'b0;
        ready_req = 1'b1;
        gap = 8'd2;
        err_at = 17'h1ffff;
        err_count = 0;
        comparisons = 0;
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        bus(1'b0, qdr_pkg::OFS_STATUS, 8'h00);
        chk(rd[7:0], qdr_pkg::RST_STATUS);
        bus(1'b0, 6'h3c, 8'h00);
        chk(rd, 32'h00000000);
        bus(1'b1, qdr_pkg::OFS_IRQ_MSK, 8'h07);
        queued(8'hc7, 8'h00, 8'h00, 5'h1f, 48'h000003abcdef, 17'd256);
        gap <= 8'd5;
        queued(8'h26, 8'h01, 8'h00, 5'h02, 48'h123456789abc, 17'd256);
        gap <= 8'd2;
        error48();
        release_service();
        for (int i = 0; i < 8; i++) begin
            log_case(logtab[i]);
        end
        close_out();
    end
endmodule
`default_nettype wire

//--- verilog/qdr_pkg.sv
// Constants, register map and state encoding of the queued read handler.
// Summary of operation
// R1 - Low device/head nibble is head or LBA 27:24
// R2 - On release: tag, REL one, I/O and C/D zero
// R3 - SRV cleared at release, set when data ready
// R4 - On completion: tag, REL zero, I/O, C/D one
// R5 - Unrecoverable error loads failing sector address
// R6 - Release bus or transfer at once if ready
// R7 - Host reselects released device with SERVICE command
// R8 - No release once data transfer has started
// R9 - Opcode 26h is 48-bit queued DMA read
// R10 - 48-bit count from features, zero means 65536
// R11 - Tag sits in sector count bits 7:3
// R12 - 48-bit LBA assembly and error LBA by HOB
// R13 - Opcode 2Fh reads log, interrupt per block
// R14 - 28-bit count from feature, zero means 256
// R15 - Log address, count and offset from registers
// R16 - Abort log read on bad feature, count, address
// R17 - Failures set status error and cause bit
package qdr_pkg;
    localparam logic [5:0] OFS_FEAT    = 6'h00;
    localparam logic [5:0] OFS_SCNT    = 6'h04;
    localparam logic [5:0] OFS_SNUM    = 6'h08;
    localparam logic [5:0] OFS_CYLO    = 6'h0c;
    localparam logic [5:0] OFS_CYHI    = 6'h10;
    localparam logic [5:0] OFS_DEVHEAD = 6'h14;
    localparam logic [5:0] OFS_CMD     = 6'h18;
    localparam logic [5:0] OFS_STATUS  = 6'h1c;
    localparam logic [5:0] OFS_ERROR   = 6'h20;
    localparam logic [5:0] OFS_DEVCTL  = 6'h24;
    localparam logic [5:0] OFS_IRQ_ST  = 6'h28;
    localparam logic [5:0] OFS_IRQ_MSK = 6'h2c;

    localparam logic [7:0] OP_RDQ     = 8'hc7;
    localparam logic [7:0] OP_RDQX    = 8'h26;
    localparam logic [7:0] OP_LOG     = 8'h2f;
    localparam logic [7:0] OP_SERVICE = 8'ha2;

    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_SRV = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_UNC = 6;
    localparam int ER_ABT = 2;
    localparam int DC_HOB = 7;
    localparam int IRQ_REL = 0;
    localparam int IRQ_CMP = 1;
    localparam int IRQ_BLK = 2;

    localparam logic [2:0] SC_RELEASE  = 3'h4;
    localparam logic [2:0] SC_COMPLETE = 3'h3;
    localparam logic [7:0] RST_STATUS  = 8'h40;
    localparam logic [16:0] CNT28_ZERO = 17'h00100;
    localparam logic [16:0] CNT48_ZERO = 17'h10000;

    localparam logic [7:0]  LOG_DIR      = 8'h00;
    localparam logic [7:0]  LOG_XERR     = 8'h03;
    localparam logic [7:0]  LOG_ST       = 8'h06;
    localparam logic [7:0]  LOG_XST      = 8'h07;
    localparam logic [7:0]  LOG_HV_LO    = 8'h80;
    localparam logic [7:0]  LOG_HV_HI    = 8'h9f;
    localparam logic [15:0] LOG_HV_LEN   = 16'h0010;
    localparam logic [15:0] LOG_DIR_LEN  = 16'h0001;
    localparam logic [15:0] LOG_SMRT_LEN = 16'h0001;

    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_QSTART  = 3'b001,
        S_REL     = 3'b010,
        S_XFER    = 3'b011,
        S_LOGCHK  = 3'b100,
        S_LOGXFER = 3'b101
    } qdr_state_e;
endpackage

//--- verilog/qdr_top.sv
// Queued DMA read and log read command handler with Avalon-MM task file.
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module qdr_top (
    input  wire logic        i_clk_sys,      // 50 MHz system clock
    input  wire logic        i_rst,          // Synchronous reset, high
    input  wire logic [5:0]  i_address,      // Avalon byte address
    input  wire logic        i_read,         // Avalon read
    input  wire logic        i_write,        // Avalon write
    input  wire logic [31:0] i_writedata,    // Avalon write data
    input  wire logic [3:0]  i_byteenable,   // Avalon byte enables
    output logic      [31:0] o_readdata,     // Avalon read data
    output logic             o_waitrequest,  // Avalon wait request
    input  wire logic        i_data_ready,   // Media data is buffered
    input  wire logic        i_sector_done,  // One DMA sector moved
    input  wire logic        i_media_err,    // Unrecoverable read error
    input  wire logic        i_smart_en,     // SMART feature set enabled
    input  wire logic        i_log_blk_done, // One log block moved
    output logic             o_dmarq,        // DMA transfer request
    output logic             o_drq,          // Log block data request
    output logic      [47:0] o_rd_lba,       // Current sector address
    output logic      [7:0]  o_log_addr,     // Log being read
    output logic      [15:0] o_log_sector,   // Log sector being read
    output logic             o_irq           // Interrupt, level high
);
    typedef struct packed {
        qdr_pkg::qdr_state_e state;
        logic        wait_q;
        logic [31:0] rdata;
        logic [7:0]  feat_c, feat_p, scnt_c, scnt_p, snum_c, snum_p;
        logic [7:0]  cyl_c, cyl_p, cyh_c, cyh_p, devhead, devctl;
        logic [7:0]  status, error;
        logic [4:0]  tag;
        logic        ext;
        logic [47:0] lba;
        logic [16:0] remain;
        logic [7:0]  logadr;
        logic [15:0] logsec;
        logic [2:0]  irq_st, irq_mask;
        logic        irq, dmarq, drq;
    } qdr_s;

    qdr_s        q;
    qdr_s        n;
    logic        acc;
    logic        wr;
    logic        cmd_go;
    logic        hob;
    logic        bsy;
    logic        fin;
    logic        fin_unc;
    logic        fin_abt;
    logic [2:0]  ev;
    logic [15:0] log_len;
    logic        log_ok;

    assign acc    = (i_read | i_write) & ~q.wait_q;
    assign wr     = acc & i_write & i_byteenable[0];
    assign cmd_go = wr & (i_address == qdr_pkg::OFS_CMD);
    assign hob    = q.devctl[qdr_pkg::DC_HOB];
    assign bsy    = q.status[qdr_pkg::ST_BSY];

    // Feature set check and length of the requested log.
    always_comb begin
        log_ok  = 1'b1;
        log_len = qdr_pkg::LOG_SMRT_LEN;
        if (q.logadr == qdr_pkg::LOG_DIR) begin
            log_len = qdr_pkg::LOG_DIR_LEN;
        end else if (q.logadr >= qdr_pkg::LOG_HV_LO &&
                     q.logadr <= qdr_pkg::LOG_HV_HI) begin
            log_len = qdr_pkg::LOG_HV_LEN;
            log_ok  = i_smart_en;
        end else if (q.logadr == qdr_pkg::LOG_XERR ||
                     q.logadr == qdr_pkg::LOG_XST) begin
            log_ok  = i_smart_en;
        end else begin
            log_ok  = 1'b0;
        end
    end

    always_comb begin
        n       = q;
        fin     = 1'b0;
        fin_unc = 1'b0;
        fin_abt = 1'b0;
        ev      = 3'h0;
        n.wait_q = ~((i_read | i_write) & q.wait_q);
        // Read data is prepared one cycle ahead of the accepting edge.
        if (i_read && q.wait_q) begin
            n.rdata = 32'h0;
            case (i_address)
                qdr_pkg::OFS_FEAT:    n.rdata[7:0] = q.feat_c;
                qdr_pkg::OFS_SCNT:    n.rdata[7:0] = hob ? q.scnt_p : q.scnt_c;
                qdr_pkg::OFS_SNUM:    n.rdata[7:0] = hob ? q.snum_p : q.snum_c;
                qdr_pkg::OFS_CYLO:    n.rdata[7:0] = hob ? q.cyl_p : q.cyl_c;
                qdr_pkg::OFS_CYHI:    n.rdata[7:0] = hob ? q.cyh_p : q.cyh_c;
                qdr_pkg::OFS_DEVHEAD: n.rdata[7:0] = q.devhead;
                qdr_pkg::OFS_STATUS:  n.rdata[7:0] = q.status;
                qdr_pkg::OFS_ERROR:   n.rdata[7:0] = q.error;
                qdr_pkg::OFS_DEVCTL:  n.rdata[7:0] = q.devctl;
                qdr_pkg::OFS_IRQ_ST:  n.rdata[2:0] = q.irq_st;
                qdr_pkg::OFS_IRQ_MSK: n.rdata[2:0] = q.irq_mask;
                default:              n.rdata = 32'h0;
            endcase
        end
        // The task file is frozen while the device is busy.
        if (wr && !bsy) begin
            case (i_address)
                qdr_pkg::OFS_FEAT: begin
                    n.feat_p = q.feat_c;
                    n.feat_c = i_writedata[7:0];
                end
                qdr_pkg::OFS_SCNT: begin
                    n.scnt_p = q.scnt_c;
                    n.scnt_c = i_writedata[7:0];
                end
                qdr_pkg::OFS_SNUM: begin
                    n.snum_p = q.snum_c;
                    n.snum_c = i_writedata[7:0];
                end
                qdr_pkg::OFS_CYLO: begin
                    n.cyl_p = q.cyl_c;
                    n.cyl_c = i_writedata[7:0];
                end
                qdr_pkg::OFS_CYHI: begin
                    n.cyh_p = q.cyh_c;
                    n.cyh_c = i_writedata[7:0];
                end
                qdr_pkg::OFS_DEVHEAD: n.devhead = i_writedata[7:0];
                default: ;
            endcase
        end
        if (wr && i_address == qdr_pkg::OFS_DEVCTL) begin
            n.devctl = i_writedata[7:0];
        end
        if (wr && i_address == qdr_pkg::OFS_IRQ_MSK) begin
            n.irq_mask = i_writedata[2:0];
        end

        case (q.state)
            qdr_pkg::S_IDLE: begin
                if (cmd_go) begin
                    n.status[qdr_pkg::ST_BSY] = 1'b1;
                    n.status[qdr_pkg::ST_ERR] = 1'b0;
                    n.error = 8'h00;
                    // R11 tag from count
                    n.tag = q.scnt_c[7:3];
                    case (i_writedata[7:0])
                        qdr_pkg::OP_RDQ: begin
                            n.ext = 1'b0;
                            // R14 28-bit count
                            n.remain = (q.feat_c == 8'h00) ?
                                qdr_pkg::CNT28_ZERO : {9'h000, q.feat_c};
                            // R1 head nibble address
                            n.lba = {20'h00000, q.devhead[3:0], q.cyh_c,
                                     q.cyl_c, q.snum_c};
                            n.state = qdr_pkg::S_QSTART;
                        end
                        // R9 48-bit queued read
                        qdr_pkg::OP_RDQX: begin
                            n.ext = 1'b1;
                            // R10 48-bit count
                            n.remain = ({q.feat_p, q.feat_c} == 16'h0000) ?
                                qdr_pkg::CNT48_ZERO
                                : {1'b0, q.feat_p, q.feat_c};
                            // R12 48-bit address assembly
                            n.lba = {q.cyh_p, q.cyl_p, q.snum_p,
                                     q.cyh_c, q.cyl_c, q.snum_c};
                            n.state = qdr_pkg::S_QSTART;
                        end
                        // R15 log read parameters
                        qdr_pkg::OP_LOG: begin
                            n.logadr = q.snum_c;
                            n.remain = {1'b0, q.scnt_p, q.scnt_c};
                            n.logsec = {q.cyl_p, q.cyl_c};
                            n.state  = qdr_pkg::S_LOGCHK;
                        end
                        default: fin_abt = 1'b1;
                    endcase
                end
            end
            qdr_pkg::S_QSTART: begin
                // R6 release or transfer
                if (i_data_ready) begin
                    n.dmarq = 1'b1;
                    n.state = qdr_pkg::S_XFER;
                end else begin
                    // R2 release code
                    n.scnt_c = {q.tag, qdr_pkg::SC_RELEASE};
                    // R3 release clears SRV
                    n.status[qdr_pkg::ST_SRV] = 1'b0;
                    n.status[qdr_pkg::ST_BSY] = 1'b0;
                    ev[qdr_pkg::IRQ_REL] = 1'b1;
                    n.state = qdr_pkg::S_REL;
                end
            end
            qdr_pkg::S_REL: begin
                // R3 ready sets SRV
                if (i_data_ready) begin
                    n.status[qdr_pkg::ST_SRV] = 1'b1;
                end
                // R7 wait for SERVICE
                if (cmd_go && i_writedata[7:0] == qdr_pkg::OP_SERVICE &&
                    q.status[qdr_pkg::ST_SRV]) begin
                    n.status[qdr_pkg::ST_BSY] = 1'b1;
                    n.status[qdr_pkg::ST_SRV] = 1'b0;
                    n.dmarq = 1'b1;
                    n.state = qdr_pkg::S_XFER;
                end
            end
            // R8 stay until all sectors or a media error
            qdr_pkg::S_XFER: begin
                if (i_media_err) begin
                    fin_unc = 1'b1;
                end else if (i_sector_done) begin
                    n.lba    = q.lba + 48'h1;
                    n.remain = q.remain - 17'h1;
                    fin      = (q.remain == 17'h1);
                end
            end
            qdr_pkg::S_LOGCHK: begin
                // R16 log abort checks
                if (!log_ok || q.remain == 17'h0 || q.logadr == qdr_pkg::LOG_ST
                    || q.logsec >= log_len) begin
                    fin_abt = 1'b1;
                end else begin
                    n.drq = 1'b1;
                    n.status[qdr_pkg::ST_DRQ] = 1'b1;
                    n.state = qdr_pkg::S_LOGXFER;
                end
            end
            qdr_pkg::S_LOGXFER: begin
                // R13 interrupt per block
                if (i_log_blk_done) begin
                    ev[qdr_pkg::IRQ_BLK] = 1'b1;
                    n.logsec = q.logsec + 16'h1;
                    n.remain = q.remain - 17'h1;
                    fin      = (q.remain == 17'h1);
                end
            end
            default: n.state = qdr_pkg::S_IDLE;
        endcase

        if (fin || fin_unc || fin_abt) begin
            n.state = qdr_pkg::S_IDLE;
            n.dmarq = 1'b0;
            n.drq   = 1'b0;
            n.status[qdr_pkg::ST_BSY] = 1'b0;
            n.status[qdr_pkg::ST_DRQ] = 1'b0;
            n.status[qdr_pkg::ST_SRV] = 1'b0;
            // R17 error and cause
            n.status[qdr_pkg::ST_ERR] = fin_unc | fin_abt;
            n.error[qdr_pkg::ER_UNC]  = fin_unc;
            n.error[qdr_pkg::ER_ABT]  = fin_abt;
            if (q.state != qdr_pkg::S_LOGXFER) begin
                ev[qdr_pkg::IRQ_CMP] = 1'b1;
            end
            if (q.state == qdr_pkg::S_XFER) begin
                // R4 completion code
                n.scnt_c = {q.tag, qdr_pkg::SC_COMPLETE};
            end
            // R5 failing sector address
            if (fin_unc) begin
                n.snum_c = q.lba[7:0];
                n.cyl_c  = q.lba[15:8];
                n.cyh_c  = q.lba[23:16];
                // R12 error LBA by HOB
                if (q.ext) begin
                    n.snum_p = q.lba[31:24];
                    n.cyl_p  = q.lba[39:32];
                    n.cyh_p  = q.lba[47:40];
                end else begin
                    n.devhead[3:0] = q.lba[27:24];
                end
            end
        end
        // Only bits returned by the read are cleared, new events win.
        if (acc && i_read && i_address == qdr_pkg::OFS_IRQ_ST) begin
            n.irq_st = q.irq_st & ~q.rdata[2:0];
        end
        n.irq_st = n.irq_st | ev;
        n.irq    = |(n.irq_st & n.irq_mask);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            q        <= '0;
            q.state  <= qdr_pkg::S_IDLE;
            q.wait_q <= 1'b1;
            q.status <= qdr_pkg::RST_STATUS;
        end else begin
            q <= n;
        end
    end

    assign o_readdata    = q.rdata;
    assign o_waitrequest = q.wait_q;
    assign o_dmarq       = q.dmarq;
    assign o_drq         = q.drq;
    assign o_rd_lba      = q.lba;
    assign o_log_addr    = q.logadr;
    assign o_log_sector  = q.logsec;
    assign o_irq         = q.irq;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_release;
        q.state == qdr_pkg::S_QSTART && !i_data_ready;
    endsequence
    sequence s_service;
        q.state == qdr_pkg::S_REL && q.status[qdr_pkg::ST_SRV] && cmd_go
            && i_writedata[7:0] == qdr_pkg::OP_SERVICE;
    endsequence

    chk_rel_code: assert property (s_release |=> // R2
        q.scnt_c == {$past(q.tag), qdr_pkg::SC_RELEASE} && (o_irq ||
        !$past(q.irq_mask[qdr_pkg::IRQ_REL])))
        else $error("release code wrong");
    chk_srv_set: assert property (s_release ##1 i_data_ready |=> // R3
        q.status[qdr_pkg::ST_SRV]) else $error("SRV not set");
    chk_service_go: assert property (s_service |=> // R7
        o_dmarq ##0 q.state == qdr_pkg::S_XFER) else $error("no resume");
    chk_no_release: assert property (q.state == qdr_pkg::S_XFER |=> // R8
        q.state inside {qdr_pkg::S_XFER, qdr_pkg::S_IDLE})
        else $error("left transfer early");
    chk_done_code: assert property (q.state == qdr_pkg::S_XFER && // R4
        !i_media_err && i_sector_done && q.remain == 17'h1 |=>
        q.scnt_c[2:0] == qdr_pkg::SC_COMPLETE && !o_dmarq &&
        !q.status[qdr_pkg::ST_SRV]) else $error("completion code wrong");
    chk_cnt28_zero: assert property (q.state == qdr_pkg::S_IDLE && // R14
        cmd_go && i_writedata[7:0] == qdr_pkg::OP_RDQ && q.feat_c == 8'h0
        |=> q.remain == qdr_pkg::CNT28_ZERO) else $error("count 256 lost");
    chk_cnt48: assert property (q.state == qdr_pkg::S_IDLE && // R10
        cmd_go && i_writedata[7:0] == qdr_pkg::OP_RDQX |=> q.remain ==
        (({$past(q.feat_p), $past(q.feat_c)} == 16'h0) ?
        qdr_pkg::CNT48_ZERO : {1'b0, $past(q.feat_p), $past(q.feat_c)}))
        else $error("48-bit count wrong");
    chk_head_lba: assert property (q.state == qdr_pkg::S_IDLE && // R1
        cmd_go && i_writedata[7:0] == qdr_pkg::OP_RDQ |=>
        o_rd_lba[27:24] == $past(q.devhead[3:0])) else $error("head lost");
    chk_unc_addr: assert property (q.state == qdr_pkg::S_XFER && // R5
        i_media_err |=> q.snum_c == $past(q.lba[7:0]) &&
        q.error[qdr_pkg::ER_UNC] && q.status[qdr_pkg::ST_ERR])
        else $error("error address wrong");
    chk_log_blk: assert property (q.state == qdr_pkg::S_LOGXFER && // R13
        i_log_blk_done |=> q.irq_st[qdr_pkg::IRQ_BLK])
        else $error("block event missed");
    chk_log_abort: assert property (q.state == qdr_pkg::S_LOGCHK && // R16
        q.remain == 17'h0 |=> q.error[qdr_pkg::ER_ABT] && !o_drq)
        else $error("log not aborted");
endmodule
`default_nettype wire
